// ### rtl/cgs_global_status.sv
// Global status, global interrupt enable and global pending registers
`timescale 1ns/1ps
`include "cgs_map.svh"

module cgs_global_status #(
  parameter int NUM_MODULES = 2
) (
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  input  wire logic [`CGS_ADDR_W-1:0]   regAddr,
  input  wire logic [`CGS_DATA_W-1:0]   regWrData,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic      [`CGS_DATA_W-1:0]   regRdData,
  input  wire logic [NUM_MODULES-1:0]   moduleInitReq,
  input  wire logic                     accValid,
  input  wire logic                     accWrite,
  input  wire cgs_pkg::cgs_acc_t        accTarget,
  input  wire logic                     accInvalidAddr,
  input  wire logic                     accMacBlock,
  output logic                          accReject,
  output logic                          accessErrorFlag,
  output logic                          globalOperation,
  output logic                          moduleReset,
  output logic                          timestampRun,
  output logic                          shutdownPermission,
  output logic                          clockSelectWrAllow,
  output logic                          searchStartWrAllow,
  output logic                          shutdownAddressErrorPending,
  output logic                          writeAccessErrorPending,
  output logic                          shutdownAddressErrorIrq,
  output logic                          writeAccessErrorIrq
);
  import cgs_pkg::*;

  // Paired set/clear: set-only sets, clear-only clears, else keep
  function automatic logic pairUpdate(input logic cur, input logic setB, input logic clrB);
    logic res;
    res = cur;
    if (setB && !clrB) begin
      res = 1'b1;
    end else if (!setB && clrB) begin
      res = 1'b0;
    end
    return res;
  endfunction

  logic                   access_error_flag_ff;
  logic                   shutdown_permission_ff;
  logic                   tsm_ff;
  logic                   gom_ff;
  logic                   ieWr_ff;
  logic                   ieSa_ff;
  logic                   pdWr_ff;
  logic                   pdSa_ff;
  logic                   irqWr_ff;
  logic                   irqSa_ff;
  logic [`CGS_DATA_W-1:0] rdData_ff;

  logic                   nxt_access_error_flag;
  logic                   nxt_shutdown_permission;
  logic                   nxt_tsm;
  logic                   nxt_gom;
  logic                   nxt_ieWr;
  logic                   nxt_ieSa;
  logic                   nxt_pdWr;
  logic                   nxt_pdSa;
  logic [`CGS_DATA_W-1:0] nxt_rdData;

  // Address decode; the port is 16 bits wide so every access is a whole word
  wire selStatus  = (regAddr == `CGS_ADDR_STATUS);
  wire selIrqEn   = (regAddr == `CGS_ADDR_IRQ_EN);
  wire selPending = (regAddr == `CGS_ADDR_PENDING);
  wire wrStatus   = regWr && selStatus;
  wire wrIrqEn    = regWr && selIrqEn;
  wire wrPending  = regWr && selPending;
  wire accStatus  = (regWr || regRd) && selStatus;

  // Field strobes of a status write
  wire setEfsd = wrStatus && regWrData[`CGS_ST_SET_SHUTDOWN_PERMISSION];
  wire clrEfsd = wrStatus && regWrData[`CGS_ST_CLR_SHUTDOWN_PERMISSION];
  wire setTsm  = wrStatus && regWrData[`CGS_ST_SET_TSM];
  wire clrTsm  = wrStatus && regWrData[`CGS_ST_CLR_TSM];
  wire setGom  = wrStatus && regWrData[`CGS_ST_SET_GOM];
  wire clrGom  = wrStatus && regWrData[`CGS_ST_CLR_GOM];
  wire clrMerr = wrStatus && regWrData[`CGS_ST_ACCESS_ERROR_FLAG];

  // A clear request on the operation bit, and whether it may take effect
  wire allInit   = &moduleInitReq;
  wire gomClrReq = clrGom && !setGom && gom_ff;
  wire gomClrBad = gomClrReq && !allInit;
  wire gomClrOk  = gomClrReq && allInit && shutdown_permission_ff;

  // Mode gating of accesses arriving at the memory access controller
  wire modRegBlk = (accTarget == CGS_ACC_MODREG) && !gom_ff;
  wire tmpBufBlk = (accTarget == CGS_ACC_TMPBUF) && gom_ff;
  wire modeBlk   = accValid && (modRegBlk || tmpBufBlk);
  wire addrBad   = accValid && accInvalidAddr;
  wire macBlk    = accValid && accMacBlock;

  // Event sources for the error flag and the two interrupts
  wire merrEvt = modeBlk || addrBad || macBlk || gomClrBad;
  wire evtWr   = modeBlk && accWrite;
  wire evtSa   = addrBad || gomClrBad;

  // Pending sets only with its enable; a new event beats a clearing write
  wire pdWrSet = evtWr && ieWr_ff;
  wire pdSaSet = evtSa && ieSa_ff;
  wire pdWrClr = wrPending && regWrData[`CGS_PD_WR];
  wire pdSaClr = wrPending && regWrData[`CGS_PD_SA];

  // Read words; unused bits read as zero
  wire [`CGS_DATA_W-1:0] statusWord  = {8'h00, access_error_flag_ff, 3'h0, shutdown_permission_ff,
                                        tsm_ff, 1'h0, gom_ff};
  wire [`CGS_DATA_W-1:0] irqEnWord   = {13'h0000, ieWr_ff, ieSa_ff, 1'h0};
  wire [`CGS_DATA_W-1:0] pendingWord = {13'h0000, pdWr_ff, pdSa_ff, 1'h0};

  // Read mux; an unmapped address reads zero
  always_comb begin
    nxt_rdData = `CGS_RST_WORD;
    if (!regRd) begin
      nxt_rdData = `CGS_RST_WORD;
    end else if (selStatus) begin
      nxt_rdData = statusWord;
    end else if (selIrqEn) begin
      nxt_rdData = irqEnWord;
    end else if (selPending) begin
      nxt_rdData = pendingWord;
    end
  end

  // Error flag: only hardware sets, only a 1 in bit 7 clears, set wins
  always_comb begin
    nxt_access_error_flag = access_error_flag_ff;
    if (merrEvt) begin
      nxt_access_error_flag = 1'b1;
    end else if (clrMerr) begin
      nxt_access_error_flag = 1'b0;
    end
  end

  // Shutdown permission: an explicit pair in this write wins, any other
  // status access drops it so the permission covers exactly one access
  always_comb begin
    nxt_shutdown_permission = shutdown_permission_ff;
    if (setEfsd != clrEfsd) begin
      nxt_shutdown_permission = pairUpdate(shutdown_permission_ff, setEfsd, clrEfsd);
    end else if (accStatus) begin
      nxt_shutdown_permission = 1'b0;
    end
  end

  // Run state pair acts on its own; the operation bit clears only with all modules initialised and shutdown permission
  always_comb begin
    nxt_tsm = pairUpdate(tsm_ff, setTsm, clrTsm);
    nxt_gom = gom_ff;
    if (setGom && !clrGom) begin
      nxt_gom = 1'b1;
    end else if (gomClrOk) begin
      nxt_gom = 1'b0;
    end
  end

  // Interrupt enables and pending bits
  always_comb begin
    nxt_ieWr = pairUpdate(ieWr_ff, wrIrqEn && regWrData[`CGS_IE_SET_WR],
                          wrIrqEn && regWrData[`CGS_IE_CLR_WR]);
    nxt_ieSa = pairUpdate(ieSa_ff, wrIrqEn && regWrData[`CGS_IE_SET_SA],
                          wrIrqEn && regWrData[`CGS_IE_CLR_SA]);
    nxt_pdWr = pdWrSet || (pdWr_ff && !pdWrClr);
    nxt_pdSa = pdSaSet || (pdSa_ff && !pdSaClr);
  end

  // Status bank state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      access_error_flag_ff <= `CGS_RST_BIT;
      shutdown_permission_ff <= `CGS_RST_BIT;
      tsm_ff  <= `CGS_RST_BIT;
      gom_ff  <= `CGS_RST_BIT;
    end else begin
      access_error_flag_ff <= nxt_access_error_flag;
      shutdown_permission_ff <= nxt_shutdown_permission;
      tsm_ff  <= nxt_tsm;
      gom_ff  <= nxt_gom;
    end
  end

  // Interrupt state; the request pulses only for an event that finds its
  // pending bit clear, so one service routine handles one burst
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ieWr_ff  <= `CGS_RST_BIT;
      ieSa_ff  <= `CGS_RST_BIT;
      pdWr_ff  <= `CGS_RST_BIT;
      pdSa_ff  <= `CGS_RST_BIT;
      irqWr_ff <= `CGS_RST_BIT;
      irqSa_ff <= `CGS_RST_BIT;
    end else begin
      ieWr_ff  <= nxt_ieWr;
      ieSa_ff  <= nxt_ieSa;
      pdWr_ff  <= nxt_pdWr;
      pdSa_ff  <= nxt_pdSa;
      irqWr_ff <= pdWrSet && !pdWr_ff;
      irqSa_ff <= pdSaSet && !pdSa_ff;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdData_ff <= `CGS_RST_WORD;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  // Outputs to the rest of the controller
  assign regRdData                   = rdData_ff;
  assign accReject                   = modeBlk || addrBad || macBlk;
  assign accessErrorFlag             = access_error_flag_ff;
  assign globalOperation             = gom_ff;
  assign moduleReset                 = !gom_ff;
  assign timestampRun                = tsm_ff;
  assign shutdownPermission          = shutdown_permission_ff;
  assign clockSelectWrAllow          = !gom_ff;
  assign searchStartWrAllow          = gom_ff;
  assign shutdownAddressErrorPending = pdSa_ff;
  assign writeAccessErrorPending     = pdWr_ff;
  assign shutdownAddressErrorIrq     = irqSa_ff;
  assign writeAccessErrorIrq         = irqWr_ff;

  // Checks on the bank
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  property p_access_error_flag_sticky;
    merrEvt |=> access_error_flag_ff;
  endproperty
  a_access_error_flag_sticky: assert property (p_access_error_flag_sticky) else $error("error flag missed an event");

  property p_access_error_flag_clear;
    clrMerr && !merrEvt |=> !access_error_flag_ff;
  endproperty
  a_access_error_flag_clear: assert property (p_access_error_flag_clear) else $error("error flag not cleared");

  property p_access_error_flag_no_sw_set;
    !access_error_flag_ff && !merrEvt |=> !access_error_flag_ff;
  endproperty
  a_access_error_flag_no_sw_set: assert property (p_access_error_flag_no_sw_set) else $error("error flag set by write");

  property p_shutdown_permission_auto;
    regRd && selStatus && shutdown_permission_ff |=> !shutdown_permission_ff;
  endproperty
  a_shutdown_permission_auto: assert property (p_shutdown_permission_auto) else $error("permission not dropped");

  property p_gom_guard;
    gom_ff && !allInit |=> gom_ff;
  endproperty
  a_gom_guard: assert property (p_gom_guard) else $error("operation cleared too early");

  property p_gom_clear;
    gomClrReq && allInit && shutdown_permission_ff |=> !gom_ff ##1 !shutdown_permission_ff || !gom_ff;
  endproperty
  a_gom_clear: assert property (p_gom_clear) else $error("operation bit kept");

  property p_modreg_block;
    accValid && accTarget == CGS_ACC_MODREG && !gom_ff |-> accReject;
  endproperty
  a_modreg_block: assert property (p_modreg_block) else $error("module access not rejected");

  property p_tmpbuf_block;
    accValid && accTarget == CGS_ACC_TMPBUF && gom_ff |-> accReject ##1 access_error_flag_ff;
  endproperty
  a_tmpbuf_block: assert property (p_tmpbuf_block) else $error("temp buffer not rejected");

  property p_pend_needs_en;
    !pdWr_ff ##1 pdWr_ff |-> $past(ieWr_ff);
  endproperty
  a_pend_needs_en: assert property (p_pend_needs_en) else $error("pending set while disabled");

  property p_status_read;
    regRd && selStatus |=> regRdData == {8'h00, $past(access_error_flag_ff), 3'h0, $past(shutdown_permission_ff),
                                         $past(tsm_ff), 1'h0, $past(gom_ff)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read word wrong");

  property p_rd_idle;
    !$past(regRd) |-> regRdData == `CGS_RST_WORD;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

  property p_irq_en_read;
    regRd && selIrqEn |=> regRdData[2:1] == {$past(ieWr_ff), $past(ieSa_ff)};
  endproperty
  a_irq_en_read: assert property (p_irq_en_read) else $error("enable read word wrong");

  // Main scenarios
  property p_cov_shutdown;
    gom_ff ##1 !gom_ff;
  endproperty
  c_cov_shutdown: cover property (p_cov_shutdown);

  property p_cov_wr_irq;
    writeAccessErrorIrq;
  endproperty
  c_cov_wr_irq: cover property (p_cov_wr_irq);

  property p_cov_bad_shutdown;
    gomClrBad ##1 access_error_flag_ff;
  endproperty
  c_cov_bad_shutdown: cover property (p_cov_bad_shutdown);

  property p_cov_ts_run;
    !tsm_ff ##1 tsm_ff;
  endproperty
  c_cov_ts_run: cover property (p_cov_ts_run);

endmodule

// ### rtl/cgs_map.svh
// Register offsets, field positions and reset values of the global status bank
`ifndef CGS_MAP_SVH
`define CGS_MAP_SVH

`define CGS_ADDR_W        22
`define CGS_DATA_W        16
`define CGS_ADDR_STATUS   22'h3FFC10
`define CGS_ADDR_IRQ_EN   22'h3FFC12
`define CGS_ADDR_PENDING  22'h3FFC20

`define CGS_RST_WORD      16'h0000
`define CGS_RST_BIT       1'h0

`define CGS_ST_ACCESS_ERROR_FLAG       7
`define CGS_ST_SET_SHUTDOWN_PERMISSION   11
`define CGS_ST_CLR_SHUTDOWN_PERMISSION   3
`define CGS_ST_SET_TSM    10
`define CGS_ST_CLR_TSM    2
`define CGS_ST_SET_GOM    8
`define CGS_ST_CLR_GOM    0

`define CGS_IE_SET_WR     10
`define CGS_IE_CLR_WR     2
`define CGS_IE_SET_SA     9
`define CGS_IE_CLR_SA     1

`define CGS_PD_WR         2
`define CGS_PD_SA         1

`endif

// ### rtl/cgs_pkg.sv
// Types shared by the global status bank
package cgs_pkg;
  // Target of an access seen by the memory access controller
  typedef enum logic [2:0] {
    CGS_ACC_MODREG,
    CGS_ACC_TMPBUF,
    CGS_ACC_MSGBUF,
    CGS_ACC_GLOBAL
  } cgs_acc_t;
endpackage

// ### verif/cgs_global_status_tb.sv
// Self-checking testbench for the global status and interrupt enable bank
`timescale 1ns/1ps
`include "cgs_map.svh"

module cgs_global_status_tb;
  import cgs_pkg::*;

  logic                   clock;
  logic                   arstN;
  logic [`CGS_ADDR_W-1:0] regAddr;
  logic [`CGS_DATA_W-1:0] regWrData;
  logic                   regWr;
  logic                   regRd;
  logic [`CGS_DATA_W-1:0] regRdData;
  logic [1:0]             moduleInitReq;
  logic                   accValid;
  logic                   accWrite;
  cgs_acc_t               accTarget;
  logic                   accInvalidAddr;
  logic                   accMacBlock;
  logic                   accReject;
  logic                   errFlag;
  logic                   global_operation;
  logic                   modReset;
  logic                   tsRun;
  logic                   perm;
  logic                   csAllow;
  logic                   ssAllow;
  logic                   saPend;
  logic                   wrPend;
  logic                   saIrq;
  logic                   wrIrq;
  int                     failCount;
  int                     checksDone;

  cgs_global_status #(.NUM_MODULES(2)) cgs_global_status_i (
    .clock(clock), .arst_n(arstN), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .moduleInitReq(moduleInitReq),
    .accValid(accValid), .accWrite(accWrite), .accTarget(accTarget),
    .accInvalidAddr(accInvalidAddr), .accMacBlock(accMacBlock), .accReject(accReject),
    .accessErrorFlag(errFlag), .globalOperation(global_operation), .moduleReset(modReset),
    .timestampRun(tsRun), .shutdownPermission(perm), .clockSelectWrAllow(csAllow),
    .searchStartWrAllow(ssAllow), .shutdownAddressErrorPending(saPend),
    .writeAccessErrorPending(wrPend), .shutdownAddressErrorIrq(saIrq),
    .writeAccessErrorIrq(wrIrq)
  );

  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic flag(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask

  // One-cycle write strobe; #1 lets the edge's updates land before any check
  task automatic wr(input logic [21:0] a, input logic [15:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rdChk(input logic [21:0] a, input logic [15:0] exp);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask

  // One access seen by the memory access controller; reject is combinational
  task automatic acc(input logic w, input cgs_acc_t t, input logic inv, input logic blk,
                     input logic expRej);
    @(posedge clock);
    accValid <= 1'b1;
    accWrite <= w;
    accTarget <= t;
    accInvalidAddr <= inv;
    accMacBlock <= blk;
    #1 flag(accReject, expRej);
    @(posedge clock);
    accValid <= 1'b0;
    accInvalidAddr <= 1'b0;
    accMacBlock <= 1'b0;
    #1;
  endtask

  task automatic testReset;
    rdChk(`CGS_ADDR_STATUS, 16'h0000);
    rdChk(`CGS_ADDR_IRQ_EN, 16'h0000);
    rdChk(`CGS_ADDR_PENDING, 16'h0000);
    flag(modReset, 1'b1);
    flag(csAllow, 1'b1);
  endtask

  task automatic testRunOp;
    wr(`CGS_ADDR_STATUS, 16'h0400);
    flag(tsRun, 1'b1);
    wr(`CGS_ADDR_STATUS, 16'h0404);
    flag(tsRun, 1'b1);
    wr(`CGS_ADDR_STATUS, 16'h0004);
    flag(tsRun, 1'b0);
    wr(`CGS_ADDR_STATUS, 16'h0500);
    rdChk(`CGS_ADDR_STATUS, 16'h0005);
    flag(ssAllow, 1'b1);
    flag(csAllow, 1'b0);
    flag(modReset, 1'b0);
    wr(`CGS_ADDR_STATUS, 16'h0101);
    flag(global_operation, 1'b1);
    wr(`CGS_ADDR_STATUS, 16'h0004);
  endtask

  task automatic testPermission;
    wr(`CGS_ADDR_STATUS, 16'h0800);
    flag(perm, 1'b1);
    wr(`CGS_ADDR_STATUS, 16'h0808);
    flag(perm, 1'b0);
    wr(`CGS_ADDR_STATUS, 16'h0800);
    rdChk(`CGS_ADDR_IRQ_EN, 16'h0000);
    flag(perm, 1'b1);
    wr(`CGS_ADDR_STATUS, 16'h0008);
    flag(perm, 1'b0);
  endtask

  task automatic testMonitor;
    wr(`CGS_ADDR_IRQ_EN, 16'h0400);
    rdChk(`CGS_ADDR_IRQ_EN, 16'h0004);
    acc(1'b1, CGS_ACC_MODREG, 1'b0, 1'b0, 1'b0);
    acc(1'b1, CGS_ACC_MSGBUF, 1'b0, 1'b0, 1'b0);
    flag(errFlag, 1'b0);
    acc(1'b1, CGS_ACC_TMPBUF, 1'b0, 1'b0, 1'b1);
    flag(wrPend, 1'b1);
    flag(wrIrq, 1'b1);
    @(posedge clock);
    #1 flag(wrIrq, 1'b0);
    rdChk(`CGS_ADDR_STATUS, 16'h0081);
    wr(`CGS_ADDR_STATUS, 16'h0000);
    flag(errFlag, 1'b1);
    wr(`CGS_ADDR_STATUS, 16'h0080);
    flag(errFlag, 1'b0);
    rdChk(`CGS_ADDR_PENDING, 16'h0004);
  endtask

  task automatic testShutdown;
    wr(`CGS_ADDR_IRQ_EN, 16'h0200);
    rdChk(`CGS_ADDR_IRQ_EN, 16'h0006);
    wr(`CGS_ADDR_STATUS, 16'h0800);
    wr(`CGS_ADDR_STATUS, 16'h0001);
    flag(global_operation, 1'b1);
    flag(errFlag, 1'b1);
    flag(saPend, 1'b1);
    flag(saIrq, 1'b1);
    @(posedge clock);
    moduleInitReq <= 2'h3;
    wr(`CGS_ADDR_STATUS, 16'h0800);
    wr(`CGS_ADDR_STATUS, 16'h0001);
    flag(global_operation, 1'b0);
    flag(modReset, 1'b1);
    flag(csAllow, 1'b1);
    flag(ssAllow, 1'b0);
    acc(1'b1, CGS_ACC_MODREG, 1'b0, 1'b0, 1'b1);
    acc(1'b1, CGS_ACC_TMPBUF, 1'b0, 1'b0, 1'b0);
    acc(1'b0, CGS_ACC_MSGBUF, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic testPending;
    wr(`CGS_ADDR_PENDING, 16'h0006);
    rdChk(`CGS_ADDR_PENDING, 16'h0000);
    wr(`CGS_ADDR_STATUS, 16'h0080);
    wr(`CGS_ADDR_IRQ_EN, 16'h0004);
    rdChk(`CGS_ADDR_IRQ_EN, 16'h0002);
    acc(1'b1, CGS_ACC_MODREG, 1'b0, 1'b0, 1'b1);
    flag(errFlag, 1'b1);
    flag(wrPend, 1'b0);
    acc(1'b0, CGS_ACC_MSGBUF, 1'b1, 1'b0, 1'b1);
    flag(saPend, 1'b1);
    wr(`CGS_ADDR_IRQ_EN, 16'h0002);
    flag(saPend, 1'b1);
    wr(`CGS_ADDR_STATUS, 16'h0080);
    acc(1'b0, CGS_ACC_MSGBUF, 1'b0, 1'b1, 1'b1);
    flag(errFlag, 1'b1);
  endtask

  // Unmapped place: write ignored, read zero, read data gone a cycle later
  task automatic testUnmapped;
    wr(22'h3FFC16, 16'hFFFF);
    rdChk(22'h3FFC16, 16'h0000);
    rdChk(`CGS_ADDR_STATUS, 16'h0080);
    @(posedge clock);
    #1 chk(regRdData, 16'h0000);
  endtask

  task automatic giveVerdict;
    if (failCount == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence: inputs idle at time zero, reset for 8 cycles
  initial begin
    failCount = 0;
    checksDone = 0;
    arstN = 1'b0;
    regAddr = '0;
    regWrData = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    moduleInitReq = 2'h1;
    accValid = 1'b0;
    accWrite = 1'b0;
    accTarget = CGS_ACC_GLOBAL;
    accInvalidAddr = 1'b0;
    accMacBlock = 1'b0;
    repeat (8) @(posedge clock);
    arstN <= 1'b1;
    testReset();
    testRunOp();
    testPermission();
    testMonitor();
    testShutdown();
    testPending();
    testUnmapped();
    giveVerdict();
  end

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #100000;
    failCount++;
    giveVerdict();
  end
endmodule
